// file: rtl/eeprom_map.vh
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// array geometry
`define ADDR_WIDTH        13
`define PAGE_BYTES        32
`define PAGE_OFS_WIDTH    5
`define ADDR_RESET        13'h0000

// serial framing
`define BITS_PER_BYTE     4'h8
`define SELECT_LOW_FIXED  2'h0

// byte kinds inside a frame
`define KIND_DEVICE       2'h0
`define KIND_ADDR_HIGH    2'h1
`define KIND_ADDR_LOW     2'h2
`define KIND_DATA         2'h3

// internal write time and its cycle count at the core clock
// the cycle count is the write time over the clock period, sized for the 24-bit timer
`define MCLK_PERIOD_NS    8'h19
`define WRITE_TIME_NS     24'h4C4B40
`define WRITE_CYCLES      24'h030D40

// read prefetch buffer
`define PREFETCH_DEPTH    16
`define PREFETCH_AW       4

`endif

// file: rtl/byte_fifo.v
// parameterised fifo with valid/ready on both sides and a flush
`timescale 1ns/10ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // storage words
    reg [AW-1:0]    wr_ptr_ff;          // next slot to fill
    reg [AW-1:0]    rd_ptr_ff;          // oldest word
    reg [AW:0]      count_ff;           // words held, one bit wider for full

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data  = mem_ff[rd_ptr_ff];

    // storage write, no reset needed on data
    always @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers and occupancy; flush empties the buffer at once
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (push & ~pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop & ~push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// file: rtl/serial_eeprom.v
// two-wire serial eeprom slave: addressing, page writes, reads, polling
`timescale 1ns/10ps
`include "eeprom_map.vh"

module serial_eeprom #(
    parameter [3:0]  DEVICE_TYPE  = 4'h5,          // arbitrary device-type code
    parameter [23:0] WRITE_CYCLES = `WRITE_CYCLES  // shorten in simulation
) (
    input  wire MCLK,
    input  wire NRST,
    input  wire SCL,
    input  wire SDA_IN,
    output reg  SDA_OUT,
    output reg  SDA_OE,
    input  wire WP,
    input  wire ADDR_SEL,
    output reg  WRITE_BUSY
);
    // bus engine states
    localparam [2:0] ST_IDLE = 3'h0; // standby, waiting for a start
    localparam [2:0] ST_RX   = 3'h1; // shifting a byte in
    localparam [2:0] ST_ACK  = 3'h2; // driving our acknowledge
    localparam [2:0] ST_TX   = 3'h3; // shifting a byte out
    localparam [2:0] ST_MACK = 3'h4; // master acknowledge slot

    // 13-bit address increment with wrap to zero
    function [`ADDR_WIDTH-1:0] inc_addr;
        input [`ADDR_WIDTH-1:0] a;
        begin
            inc_addr = a + 1'b1;
        end
    endfunction

    // three-stage synchronisers for every input pin except NRST
    reg  [2:0] scl_sync_ff;     // scl stages
    reg  [2:0] sda_sync_ff;     // sda stages
    reg  [2:0] wp_sync_ff;      // write protect stages
    reg  [2:0] sel_sync_ff;     // address select stages
    reg        scl_lv_ff;       // accepted scl level
    reg        sda_lv_ff;       // accepted sda level
    reg        wp_lv_ff;        // accepted protect level
    reg        sel_lv_ff;       // accepted select level
    reg        scl_d_ff;        // scl level one cycle ago
    reg        sda_d_ff;        // sda level one cycle ago

    // bus engine
    reg  [2:0]              state_ff;    // engine state
    reg  [3:0]              bit_cnt_ff;  // bits moved in this byte
    reg  [7:0]              shift_ff;    // receive / transmit shifter
    reg  [1:0]              kind_ff;     // what the current byte means
    reg                     rd_dir_ff;   // current frame is a read
    reg                     mack_ff;     // master pulled ack low
    reg  [7:0]              addr_hi_ff;  // received high address byte
    reg  [`ADDR_WIDTH-1:0]  base_ff;     // address given in this write
    reg  [`ADDR_WIDTH-1:0]  counter_ff;  // internal address counter
    reg  [5:0]              bytes_ff;    // data bytes loaded, saturates at 33
    reg                     wr_pend_ff;  // data loaded, waiting for stop
    reg  [`PAGE_BYTES-1:0]  pvalid_ff;   // page latch slots holding data
    reg  [7:0]              page_ff [0:`PAGE_BYTES-1]; // page latch

    // internal write cycle
    reg  [23:0]             wc_cnt_ff;   // cycles left in the write
    reg  [5:0]              commit_ff;   // page slot being committed

    // array and prefetch
    reg  [7:0]              array_ff [0:(1<<`ADDR_WIDTH)-1]; // the array
    reg  [7:0]              rd_data_ff;  // registered array read
    reg  [`ADDR_WIDTH-1:0]  pf_addr_ff;  // next address to prefetch
    reg                     pf_pend_ff;  // read issued, data lands next cycle

    // level accepted only when second and third stages agree
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            wp_sync_ff  <= 3'h0;
            sel_sync_ff <= 3'h0;
            scl_lv_ff   <= 1'b1;
            sda_lv_ff   <= 1'b1;
            wp_lv_ff    <= 1'b0;
            sel_lv_ff   <= 1'b0;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], SCL};
            sda_sync_ff <= {sda_sync_ff[1:0], SDA_IN};
            wp_sync_ff  <= {wp_sync_ff[1:0], WP};
            sel_sync_ff <= {sel_sync_ff[1:0], ADDR_SEL};
            if (scl_sync_ff[1] == scl_sync_ff[2]) begin
                scl_lv_ff <= scl_sync_ff[2];
            end
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_lv_ff <= sda_sync_ff[2];
            end
            if (wp_sync_ff[1] == wp_sync_ff[2]) begin
                wp_lv_ff <= wp_sync_ff[2];
            end
            if (sel_sync_ff[1] == sel_sync_ff[2]) begin
                sel_lv_ff <= sel_sync_ff[2];
            end
            scl_d_ff <= scl_lv_ff;
            sda_d_ff <= sda_lv_ff;
        end
    end

    // bus events from accepted levels
    wire scl_rise   = scl_lv_ff & ~scl_d_ff;
    wire scl_fall   = ~scl_lv_ff & scl_d_ff;
    wire start_cond = scl_lv_ff & scl_d_ff & sda_d_ff & ~sda_lv_ff;
    wire stop_cond  = scl_lv_ff & scl_d_ff & ~sda_d_ff & sda_lv_ff;

    // address byte match: type code, fixed low selects, strapped high select
    wire dev_match = (shift_ff[7:4] == DEVICE_TYPE) &
                     (shift_ff[3] == sel_lv_ff) &
                     (shift_ff[2:1] == `SELECT_LOW_FIXED);

    // page slot for the next data byte: only the low five bits advance
    wire [`PAGE_OFS_WIDTH-1:0] load_ofs = base_ff[4:0] + bytes_ff[4:0];

    // a write cycle starts only with loaded data, a stop, and protect low
    wire wc_go = ~WRITE_BUSY & stop_cond & wr_pend_ff & ~wp_lv_ff;

    // prefetch fifo wiring
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg        tx_load;          // engine takes a byte this cycle
    wire       pf_issue = ~pf_pend_ff & fifo_in_ready & ~WRITE_BUSY & ~start_cond;

    // engine pops the prefetch buffer when loading the shifter
    always @* begin
        tx_load = 1'b0;
        if (!WRITE_BUSY && !start_cond && !stop_cond && scl_fall) begin
            if (state_ff == ST_ACK && rd_dir_ff) begin
                tx_load = 1'b1;
            end else if (state_ff == ST_MACK && mack_ff) begin
                tx_load = 1'b1;
            end
        end
    end

    // next byte to send; an empty buffer reads as all ones, which the slow bus never sees
    wire [7:0] tx_byte = fifo_out_valid ? fifo_out_data : 8'hFF;

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (`PREFETCH_DEPTH),
        .AW    (`PREFETCH_AW)
    ) u_prefetch (
        .clk       (MCLK),
        .rst_n     (NRST),
        .flush     (start_cond),
        .in_valid  (pf_pend_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (rd_data_ff),
        .out_valid (fifo_out_valid),
        .out_ready (tx_load),
        .out_data  (fifo_out_data)
    );

    // bus engine: bit shifting, acknowledges, address and page handling
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            kind_ff    <= `KIND_DEVICE;
            rd_dir_ff  <= 1'b0;
            mack_ff    <= 1'b0;
            addr_hi_ff <= 8'h00;
            base_ff    <= `ADDR_RESET;
            counter_ff <= `ADDR_RESET;
            bytes_ff   <= 6'h00;
            wr_pend_ff <= 1'b0;
            pvalid_ff  <= {`PAGE_BYTES{1'b0}};
            SDA_OUT    <= 1'b0;
            SDA_OE     <= 1'b0;
        end else if (WRITE_BUSY) begin
            // bus pins ignored during the write, so polls and bus resets go unanswered; NRST still resets
            state_ff   <= ST_IDLE;
            SDA_OE     <= 1'b0;
            wr_pend_ff <= 1'b0;
        end else if (start_cond) begin
            // any start, repeated or after dummy clocks, aborts the partial command
            state_ff   <= ST_RX;
            kind_ff    <= `KIND_DEVICE;
            bit_cnt_ff <= 4'h0;
            SDA_OE     <= 1'b0;
            wr_pend_ff <= 1'b0;
        end else if (stop_cond) begin
            state_ff   <= ST_IDLE;
            SDA_OE     <= 1'b0;
            wr_pend_ff <= 1'b0;
            if (wr_pend_ff) begin
                if (bytes_ff > `PAGE_BYTES) begin
                    counter_ff <= base_ff;
                end else begin
                    counter_ff <= {base_ff[12:5], load_ofs};
                end
            end
        end else begin
            case (state_ff)
                ST_RX: begin
                    if (scl_rise) begin
                        // sample on the rising edge, msb first
                        shift_ff   <= {shift_ff[6:0], sda_lv_ff};
                        bit_cnt_ff <= bit_cnt_ff + 1'b1;
                    end else if (scl_fall && bit_cnt_ff == `BITS_PER_BYTE) begin
                        bit_cnt_ff <= 4'h0;
                        case (kind_ff)
                            `KIND_DEVICE: begin
                                if (dev_match) begin
                                    SDA_OE    <= 1'b1;
                                    state_ff  <= ST_ACK;
                                    rd_dir_ff <= shift_ff[0];
                                    kind_ff   <= `KIND_ADDR_HIGH;
                                end else begin
                                    state_ff  <= ST_IDLE;
                                end
                            end
                            `KIND_ADDR_HIGH: begin
                                addr_hi_ff <= shift_ff;
                                SDA_OE     <= 1'b1;
                                state_ff   <= ST_ACK;
                                kind_ff    <= `KIND_ADDR_LOW;
                            end
                            `KIND_ADDR_LOW: begin
                                // upper address bits beyond the array are dropped
                                base_ff    <= {addr_hi_ff[4:0], shift_ff};
                                counter_ff <= {addr_hi_ff[4:0], shift_ff};
                                bytes_ff   <= 6'h00;
                                pvalid_ff  <= {`PAGE_BYTES{1'b0}};
                                SDA_OE     <= 1'b1;
                                state_ff   <= ST_ACK;
                                kind_ff    <= `KIND_DATA;
                            end
                            default: begin
                                // data byte into the page latch; wrap overwrites earlier slots
                                page_ff[load_ofs]  <= shift_ff;
                                pvalid_ff[load_ofs] <= 1'b1;
                                if (bytes_ff <= `PAGE_BYTES) begin
                                    bytes_ff <= bytes_ff + 1'b1;
                                end
                                wr_pend_ff <= 1'b1;
                                SDA_OE     <= 1'b1;
                                state_ff   <= ST_ACK;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (rd_dir_ff) begin
                            // first read byte comes from the counter address
                            shift_ff   <= {tx_byte[6:0], 1'b0};
                            SDA_OE     <= ~tx_byte[7];
                            counter_ff <= inc_addr(counter_ff);
                            state_ff   <= ST_TX;
                        end else begin
                            SDA_OE   <= 1'b0;
                            state_ff <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 1'b1;
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == `BITS_PER_BYTE) begin
                            SDA_OE   <= 1'b0;                                 // release for master ack
                            state_ff <= ST_MACK;
                            mack_ff  <= 1'b0;
                        end else begin
                            SDA_OE   <= ~shift_ff[7];
                            shift_ff <= {shift_ff[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_ff <= ~sda_lv_ff;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (mack_ff) begin
                            // low ack: next byte, address wraps past the end
                            shift_ff   <= {tx_byte[6:0], 1'b0};
                            SDA_OE     <= ~tx_byte[7];
                            counter_ff <= inc_addr(counter_ff);
                            state_ff   <= ST_TX;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    SDA_OE   <= 1'b0;
                end
            endcase
        end
    end

    // internal write timer; page latch commits in its first cycles
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            WRITE_BUSY <= 1'b0;
            wc_cnt_ff  <= 24'h000000;
            commit_ff  <= 6'h00;
        end else if (wc_go) begin
            WRITE_BUSY <= 1'b1;
            wc_cnt_ff  <= WRITE_CYCLES;
            commit_ff  <= 6'h00;
        end else if (WRITE_BUSY) begin
            if (commit_ff != 6'h20) begin
                commit_ff <= commit_ff + 1'b1;
            end
            if (wc_cnt_ff <= 24'h000001) begin
                WRITE_BUSY <= 1'b0;
            end else begin
                wc_cnt_ff <= wc_cnt_ff - 1'b1;
            end
        end
    end

    // array port: commit writes during busy, prefetch reads otherwise
    always @(posedge MCLK) begin
        if (WRITE_BUSY && commit_ff != 6'h20 && pvalid_ff[commit_ff[4:0]]) begin
            array_ff[{base_ff[12:5], commit_ff[4:0]}] <= page_ff[commit_ff[4:0]];
        end
        rd_data_ff <= array_ff[pf_addr_ff];
    end

    // prefetch pointer follows the counter on every start
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pf_addr_ff <= `ADDR_RESET;
            pf_pend_ff <= 1'b0;
        end else if (start_cond) begin
            pf_addr_ff <= counter_ff;
            pf_pend_ff <= 1'b0;
        end else begin
            pf_pend_ff <= pf_issue;
            if (pf_pend_ff) begin
                // the read registered last cycle lands in the buffer now
                pf_addr_ff <= inc_addr(pf_addr_ff);
            end
        end
    end
endmodule

// file: verif/serial_eeprom_properties.sv
// port checker for the serial eeprom slave
`timescale 1ns/10ps
module serial_eeprom_properties #(
    parameter [23:0] WRITE_CYCLES = 24'h030D40 // length of one internal write
) (
    input wire MCLK,
    input wire NRST,
    input wire SCL,
    input wire SDA_IN,
    input wire SDA_OUT,
    input wire SDA_OE,
    input wire WP,
    input wire ADDR_SEL,
    input wire WRITE_BUSY
);
    reg [23:0] busy_cnt_ff; // cycles spent busy so far
    reg [3:0]  age_ff;      // cycles since the bus clock fell
    reg        scl_ff;      // bus clock one cycle back
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // helper counters; the age saturates so long idle spans cannot wrap
    always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            busy_cnt_ff <= 24'h000000;
            age_ff      <= 4'hF;
            scl_ff      <= 1'b1;
        end else begin
            busy_cnt_ff <= WRITE_BUSY ? busy_cnt_ff + 24'h000001 : 24'h000000;
            age_ff      <= (scl_ff && !SCL) ? 4'h0 : ((age_ff == 4'hF) ? age_ff : age_ff + 4'h1);
            scl_ff      <= SCL;
        end
    end
    property p_drain; SDA_OUT == 1'b0; endproperty
    a_drain: assert property (p_drain) else $error("data pin driven high");
    property p_busy_mute; WRITE_BUSY |-> !SDA_OE; endproperty
    a_busy_mute: assert property (p_busy_mute) else $error("answer while busy");
    property p_oe_after_fall; $changed(SDA_OE) |-> (age_ff >= 4'h2 && age_ff <= 4'h5); endproperty
    a_oe_after_fall: assert property (p_oe_after_fall) else $error("data out moved off clock fall");
    property p_busy_at_stop; $rose(WRITE_BUSY) |-> SCL && SDA_IN; endproperty
    a_busy_at_stop: assert property (p_busy_at_stop) else $error("write began without stop");
    property p_busy_unprot; $rose(WRITE_BUSY) |-> !WP; endproperty
    a_busy_unprot: assert property (p_busy_unprot) else $error("write began while protected");
    property p_busy_len; $fell(WRITE_BUSY) |-> busy_cnt_ff == WRITE_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_busy_hold; $rose(WRITE_BUSY) |=> WRITE_BUSY [*8]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");
    property p_start_quiet; SCL && !SDA_OE && $fell(SDA_IN) |-> !SDA_OE [*8]; endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("driven right after start");
endmodule

// file: verif/bus_master.sv
// behavioural two-wire bus master driving the slave's bus pins
`timescale 1ns/10ps
module bus_master (
    input  wire logic mclk,    // pins change just after its rising edge
    input  wire logic sda,     // resolved data line
    output logic      scl,     // bus clock, stands high between frames
    output logic      sda_pull // high while the master pulls data low
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one bit: data moves a cycle after the fall so hold is never zero;
    // the low phase outlasts the slave's five-cycle pin latency, so its data never moves while scl is high
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_pull <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(2);
        r = sda; // late in the high phase, after slave data has settled
        scl <= 1'b0;
    endtask
    // start or repeated start; first lets the slave drop its last bit
    task automatic start();
        tick(1);
        sda_pull <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    // stop, leaves the bus idle
    task automatic stop();
        tick(1);
        sda_pull <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b0;
        tick(8);
    endtask
    // eight bits msb first plus the answer slot; rx collects the line
    task automatic byte_io(input logic [8:0] t, output logic [8:0] rx);
        logic r;
        for (int i = 8; i >= 0; i--) begin
            bit_io(t[i], r);
            rx = {rx[7:0], r};
        end
    endtask
endmodule

// file: verif/serial_eeprom_bench.sv
// self-checking bench for the two-wire serial eeprom slave
`timescale 1ns/10ps
module serial_eeprom_bench;
    localparam [3:0]  TYPE_CODE = 4'h6;              // arbitrary type code
    localparam [23:0] WR_CYCLES = 24'h0000C8;        // shortened write time
    localparam [6:0]  DEV       = {TYPE_CODE, 3'h4}; // upper select high
    logic       mclk;       // core clock
    logic       nrst;       // reset, active low
    logic       wp;         // write protect pin
    logic       addr_sel;   // select strap, high until the last test
    logic       scl;        // bus clock
    logic       sda_pull;   // master pulls data low
    logic [8:0] rx;         // last nine bus bits
    wire        sda_oe;     // slave pulls data low
    wire        sda_out;    // slave drive level
    wire        write_busy; // internal write running
    wire        sda_line = !(sda_pull || (sda_oe && !sda_out)); // pull-up
    int         failures;
    int         total_checks;
    serial_eeprom #(.DEVICE_TYPE(TYPE_CODE), .WRITE_CYCLES(WR_CYCLES)) serial_eeprom_i (
        .MCLK(mclk), .NRST(nrst), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .WP(wp), .ADDR_SEL(addr_sel), .WRITE_BUSY(write_busy));
    bus_master bus_master_i (.mclk(mclk), .sda(sda_line), .scl(scl), .sda_pull(sda_pull));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // byte out; nak high when a refusal is expected
    task automatic put(input logic [7:0] tx, input logic nak);
        bus_master_i.byte_io({tx, 1'b1}, rx);
        chk("ack", {8'h00, rx[0]}, {8'h00, nak});
    endtask
    // byte in, answered with mack
    task automatic get(input logic [7:0] exp, input logic mack);
        bus_master_i.byte_io({8'hFF, mack}, rx);
        chk("rdata", {1'b0, rx[8:1]}, {1'b0, exp});
    endtask
    // device byte for a write, then both address bytes
    task automatic frame(input logic [7:0] hi, input logic [7:0] lo);
        bus_master_i.start();
        put({DEV, 1'b0}, 1'b0);
        put(hi, 1'b0);
        put(lo, 1'b0);
    endtask
    // open a read at the counter
    task automatic rd();
        bus_master_i.start();
        put({DEV, 1'b1}, 1'b0);
    endtask
    // bounded wait for the write cycle to end
    task automatic idle();
        for (int n = 0; n < 400 && write_busy !== 1'b0; n++) @(posedge mclk);
        chk("busy", {8'h00, write_busy}, 9'h000);
    endtask
    initial begin
        // non-blocking so the reset edge lands after every process is waiting
        nrst <= 1'b0;
        wp <= 1'b1;
        addr_sel <= 1'b1;
        failures = 0;
        total_checks = 0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        // foreign select or type codes are refused
        bus_master_i.start();
        put({TYPE_CODE, 3'h0, 1'b0}, 1'b1);
        bus_master_i.start();
        put({TYPE_CODE, 3'h5, 1'b1}, 1'b1);
        bus_master_i.start();
        put({~TYPE_CODE, 3'h4, 1'b0}, 1'b1);
        // protected write must not start a cycle
        frame(8'h00, 8'h00);
        put(8'h5A, 1'b0);
        bus_master_i.stop();
        chk("busy", {8'h00, write_busy}, 9'h000);
        wp <= 1'b0;
        frame(8'h00, 8'h00);
        put(8'hC3, 1'b0);
        bus_master_i.stop();
        chk("busy", {8'h00, write_busy}, 9'h001);
        bus_master_i.start();
        put({DEV, 1'b0}, 1'b1);
        idle();
        bus_master_i.start();
        put({DEV, 1'b0}, 1'b0);
        // 33 bytes from the page's last slot, high address bits ignored
        frame(8'hFF, 8'hFF);
        for (int i = 0; i < 33; i++) put(8'h40 + i[7:0], 1'b0);
        bus_master_i.stop();
        idle();
        rd();
        get(8'h60, 1'b0);
        get(8'hC3, 1'b1);
        bus_master_i.stop();
        // random read, sequential within the wrapped page
        frame(8'h1F, 8'hE0);
        rd();
        get(8'h41, 1'b0);
        get(8'h42, 1'b1);
        bus_master_i.stop();
        // aborted command, then start plus nine released clocks plus start
        frame(8'h1F, 8'hE2);
        put(8'h99, 1'b0);
        bus_master_i.start();
        for (int i = 0; i < 9; i++) bus_master_i.bit_io(1'b1, rx[0]);
        rd();
        get(8'h43, 1'b1);
        bus_master_i.stop();
        chk("busy", {8'h00, write_busy}, 9'h000);
        // write ending on the page's last slot wraps the counter in page
        frame(8'h1F, 8'hFE);
        put(8'h71, 1'b0);
        put(8'h72, 1'b0);
        bus_master_i.stop();
        idle();
        rd();
        get(8'h41, 1'b1);
        bus_master_i.stop();
        // a fresh reset clears the counter but keeps the array
        nrst <= 1'b0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        rd();
        get(8'hC3, 1'b1);
        bus_master_i.stop();
        // strap low moves the device to the other select code
        addr_sel <= 1'b0;
        bus_master_i.start();
        put({TYPE_CODE, 3'h0, 1'b0}, 1'b0);
        bus_master_i.start();
        put({DEV, 1'b0}, 1'b1);
        bus_master_i.stop();
        close_out();
    end
    // watchdog well past the roughly 6500 cycles the tests need
    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        close_out();
    end
endmodule
bind serial_eeprom serial_eeprom_properties #(.WRITE_CYCLES(WRITE_CYCLES)) serial_eeprom_properties_i (
    .MCLK(MCLK), .NRST(NRST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .WP(WP), .ADDR_SEL(ADDR_SEL), .WRITE_BUSY(WRITE_BUSY));
